// ---- include/fbss_defs.vh ----
// Purpose: shared constants of the fieldbus slave sequencer
// Assumes: 25 MHz system clock
// Notes: definitions only, no logic
`ifndef FBSS_DEFS_VH
`define FBSS_DEFS_VH

// clock and timing
`define FBSS_CLK_HZ 25000000
`define FBSS_BLINK_MS 250
`define FBSS_QUIET_MS 100
`define FBSS_BLINK_CYC (`FBSS_CLK_HZ / 1000 * `FBSS_BLINK_MS)
`define FBSS_QUIET_CYC (`FBSS_CLK_HZ / 1000 * `FBSS_QUIET_MS)

// bit rate range
`define FBSS_MIN_RATE 9600
`define FBSS_MAX_PER (`FBSS_CLK_HZ / `FBSS_MIN_RATE)
`define FBSS_PER_W 16
`define FBSS_LOCK_EDGES 4'h8

// station address range
`define FBSS_ADDR_MIN 7'h01
`define FBSS_ADDR_MAX 7'h7D

// frame layout
`define FBSS_POS_ADDR 8'h00
`define FBSS_POS_TYPE 8'h01
`define FBSS_POS_PAY 8'h02
`define FBSS_PRM_MIN_LEN 8'h07

// request frame types
`define FBSS_FT_PRM 8'h01
`define FBSS_FT_CFG 8'h02
`define FBSS_FT_DX 8'h03

// answer frame types
`define FBSS_RS_ACK 8'h10
`define FBSS_RS_DIN 8'h11
`define FBSS_RS_DIAG 8'h12

// configuration module codes
`define FBSS_CFG_BOX 8'h12
`define FBSS_CFG_HEAD 8'h51
`define FBSS_MAX_HEADS 4'h8

// diagnostic codes
`define FBSS_DG_SEQ 8'h01
`define FBSS_DG_PRM 8'h02
`define FBSS_DG_CFG 8'h04
`define FBSS_DG_DX 8'h08
`define FBSS_DG_HEAD 8'h10

// answer lengths
`define FBSS_LEN_ACK 6'h01
`define FBSS_LEN_DIAG 6'h02
`define FBSS_LEN_DIN0 6'h02

// sequencer states
`define FBSS_ST_WPRM 2'h0
`define FBSS_ST_WCFG 2'h1
`define FBSS_ST_DX 2'h2

// input data fields
`define FBSS_TRIG_BIT 0

`endif

// ---- core/fbss_buf2.v ----
// Purpose: two-entry skid buffer with valid and ready on both sides
// Assumes: one clock, synchronous active-high reset
// Notes: output side driven straight from registers
`timescale 1ns/1ps
module fbss_buf2 #(
	parameter WIDTH = 9
) (
	// clock and reset
	input wire sys_clk_i,
	input wire srst_i,
	// filling side
	input wire in_valid_i,
	input wire [WIDTH-1:0] in_data_i,
	output reg in_ready_o,
	// draining side
	output reg out_valid_o,
	output reg [WIDTH-1:0] out_data_o,
	input wire out_ready_i
);

reg spare_valid;
reg [WIDTH-1:0] spare_data;
wire push = in_valid_i && in_ready_o;
wire pop = out_valid_o && out_ready_i;

// head register, spare register and ready
always @(posedge sys_clk_i) begin
	if (srst_i) begin
		out_valid_o <= 1'b0;
		out_data_o <= {WIDTH{1'b0}};
		spare_valid <= 1'b0;
		spare_data <= {WIDTH{1'b0}};
		in_ready_o <= 1'b0;
	end else begin
		if (!out_valid_o || pop) begin
			if (spare_valid) begin
				out_valid_o <= 1'b1;
				out_data_o <= spare_data;
				spare_valid <= push;
				spare_data <= in_data_i;
			end else begin
				out_valid_o <= push;
				out_data_o <= in_data_i;
			end
		end else if (push) begin
			spare_valid <= 1'b1;
			spare_data <= in_data_i;
		end
		// ready drops once both entries would hold data
		in_ready_o <= !(out_valid_o && !pop && (spare_valid || push));
	end
end

endmodule // fbss_buf2

// ---- core/fbss_seq.v ----
// Purpose: fieldbus slave start-up, cyclic exchange and diagnostics
// Assumes: byte-level link from an outer bit receiver, 25 MHz clock
// Notes: answers leave through a two-entry buffer
`timescale 1ns/1ps
`include "fbss_defs.vh"
module fbss_seq #(
	parameter BLINK_CYC = `FBSS_BLINK_CYC,
	parameter QUIET_CYC = `FBSS_QUIET_CYC
) (
	// clock and reset
	input wire sys_clk_i,
	input wire srst_i,
	// station setting and line
	input wire [6:0] station_addr_i,
	input wire line_rx_i,
	// received bytes
	input wire rx_valid_i,
	input wire [7:0] rx_data_i,
	input wire rx_last_i,
	input wire rx_err_i,
	// sensor side
	input wire trigger_i,
	input wire [127:0] obj_temp_i,
	input wire [127:0] head_temp_i,
	input wire head_fault_i,
	// answer bytes
	output wire tx_valid_o,
	output wire [7:0] tx_data_o,
	output wire tx_last_o,
	input wire tx_ready_i,
	// applied output data
	output reg app_we_o,
	output reg [7:0] app_idx_o,
	output reg [7:0] app_data_o,
	// status
	output reg [`FBSS_PER_W-1:0] bit_period_o,
	output reg rate_lock_o,
	output reg [3:0] heads_o,
	output reg led_red_o,
	output reg led_yellow_o
);

reg [1:0] state;
reg [6:0] station;
reg station_ok;
reg [7:0] pos;
reg mine;
reg [7:0] ftype;
reg bad;
reg cfg_bad;
reg [3:0] heads_seen;
reg diag_flag;
reg resp_busy;
reg [7:0] resp_kind;
reg [7:0] resp_code;
reg [5:0] resp_idx;
reg [5:0] resp_len;
reg resp_trig;
reg [255:0] snap;
reg [31:0] quiet;
reg [31:0] blink;
reg line_q;
reg [`FBSS_PER_W-1:0] gap;
reg [3:0] edges;
wire buf_ready;

// values as they stand with the current byte included
wire [7:0] fin_type = (pos == `FBSS_POS_TYPE) ? rx_data_i : ftype;
wire [7:0] fin_len = (pos >= `FBSS_POS_PAY) ? pos - `FBSS_POS_TYPE : 8'h00;
wire fin_mine = (pos == `FBSS_POS_ADDR) ? 1'b0 : mine;
wire fin_bad = bad || rx_err_i;
wire is_pay = (pos >= `FBSS_POS_PAY);
wire cur_box = (pos == `FBSS_POS_PAY);
wire cur_cfg_bad = cur_box ? (rx_data_i != `FBSS_CFG_BOX) :
	(rx_data_i != `FBSS_CFG_HEAD) || (heads_seen == `FBSS_MAX_HEADS);
wire fin_cfg_bad = cfg_bad || (is_pay && cur_cfg_bad) || (fin_len == 8'h00);
wire [3:0] fin_heads = (is_pay && !cur_box) ? heads_seen + 4'h1 : heads_seen;
wire frame_end = rx_valid_i && rx_last_i && fin_mine && !resp_busy;
wire quiet_hit = (quiet >= QUIET_CYC);

// station address sampled every cycle, range checked
always @(posedge sys_clk_i) begin
	if (srst_i) begin
		station <= 7'h00;
		station_ok <= 1'b0;
	end else begin
		station <= station_addr_i;
		station_ok <= (station_addr_i >= `FBSS_ADDR_MIN) &&
			(station_addr_i <= `FBSS_ADDR_MAX);
	end
end

// frame parser and start-up sequencer
always @(posedge sys_clk_i) begin
	if (srst_i) begin
		state <= `FBSS_ST_WPRM;
		pos <= 8'h00;
		mine <= 1'b0;
		ftype <= 8'h00;
		bad <= 1'b0;
		cfg_bad <= 1'b0;
		heads_seen <= 4'h0;
		heads_o <= 4'h0;
		app_we_o <= 1'b0;
		app_idx_o <= 8'h00;
		app_data_o <= 8'h00;
		resp_busy <= 1'b0;
		resp_kind <= 8'h00;
		resp_code <= 8'h00;
		resp_idx <= 6'h00;
		resp_len <= 6'h00;
		resp_trig <= 1'b0;
		snap <= 256'h0;
		diag_flag <= 1'b0;
	end else begin
		app_we_o <= 1'b0;
		if (rx_valid_i) begin
			pos <= rx_last_i ? 8'h00 : ((pos == 8'hFF) ? pos : pos + 8'h01);
			if (pos == `FBSS_POS_ADDR) begin
				mine <= station_ok && (rx_data_i == {1'b0, station});
				bad <= rx_err_i;
				cfg_bad <= 1'b0;
				heads_seen <= 4'h0;
			end else begin
				bad <= bad || rx_err_i;
				if (pos == `FBSS_POS_TYPE)
					ftype <= rx_data_i;
				if (is_pay) begin
					cfg_bad <= cfg_bad || cur_cfg_bad;
					heads_seen <= (cur_cfg_bad || cur_box) ? heads_seen : fin_heads;
				end
				if (mine && is_pay && ftype == `FBSS_FT_DX && state == `FBSS_ST_DX) begin
					app_we_o <= 1'b1;
					app_idx_o <= pos - `FBSS_POS_PAY;
					app_data_o <= rx_data_i;
				end
			end
		end
		// answer bytes leave one per accepted push
		if (resp_busy && buf_ready) begin
			resp_idx <= resp_idx + 6'h01;
			if (resp_idx == resp_len - 6'h01)
				resp_busy <= 1'b0;
		end
		// decision at frame end
		if (frame_end) begin
			resp_busy <= 1'b1;
			resp_idx <= 6'h00;
			resp_kind <= `FBSS_RS_DIAG;
			resp_len <= `FBSS_LEN_DIAG;
			resp_code <= `FBSS_DG_SEQ;
			case (fin_type)
			`FBSS_FT_PRM: begin
				if (!fin_bad && fin_len >= `FBSS_PRM_MIN_LEN) begin
					state <= `FBSS_ST_WCFG;
					resp_kind <= `FBSS_RS_ACK;
					resp_len <= `FBSS_LEN_ACK;
				end else begin
					state <= `FBSS_ST_WPRM;
					resp_code <= `FBSS_DG_PRM;
				end
			end
			`FBSS_FT_CFG: begin
				if (state != `FBSS_ST_WCFG) begin
					state <= `FBSS_ST_WPRM;
				end else if (!fin_bad && !fin_cfg_bad) begin
					state <= `FBSS_ST_DX;
					heads_o <= fin_heads;
					resp_kind <= `FBSS_RS_ACK;
					resp_len <= `FBSS_LEN_ACK;
				end else begin
					state <= `FBSS_ST_WPRM;
					resp_code <= `FBSS_DG_CFG;
				end
			end
			`FBSS_FT_DX: begin
				if (state != `FBSS_ST_DX) begin
					resp_code <= `FBSS_DG_SEQ;
				end else if (fin_bad) begin
					resp_code <= `FBSS_DG_DX;
				end else if (diag_flag || head_fault_i) begin
					resp_code <= `FBSS_DG_HEAD;
				end else begin
					resp_kind <= `FBSS_RS_DIN;
					resp_len <= `FBSS_LEN_DIN0 + {heads_o, 2'b00};
					resp_trig <= trigger_i;
					snap <= {obj_temp_i[127:112], head_temp_i[127:112],
						obj_temp_i[111:96], head_temp_i[111:96],
						obj_temp_i[95:80], head_temp_i[95:80],
						obj_temp_i[79:64], head_temp_i[79:64],
						obj_temp_i[63:48], head_temp_i[63:48],
						obj_temp_i[47:32], head_temp_i[47:32],
						obj_temp_i[31:16], head_temp_i[31:16],
						obj_temp_i[15:0], head_temp_i[15:0]};
				end
			end
			default: begin
				resp_code <= `FBSS_DG_SEQ;
			end
			endcase
		end else if (quiet_hit && state != `FBSS_ST_WPRM) begin
			// silent master: start-up must be repeated
			state <= `FBSS_ST_WPRM;
		end
		// head fault sticky until the next exchange frame ends in exchange, even one answered with the frame error code; a new fault wins
		if (head_fault_i && state == `FBSS_ST_DX)
			diag_flag <= 1'b1;
		else if (frame_end && fin_type == `FBSS_FT_DX && state == `FBSS_ST_DX)
			diag_flag <= 1'b0;
	end
end

// answer byte selection
wire [5:0] hb = resp_idx - `FBSS_LEN_DIN0;
wire [4:0] bsel = {hb[4:2], ~hb[1:0]};
reg [7:0] tx_byte;
always @* begin
	tx_byte = 8'h00;
	if (resp_idx == 6'h00)
		tx_byte = resp_kind;
	else if (resp_kind == `FBSS_RS_DIAG)
		tx_byte = resp_code;
	else if (resp_idx == 6'h01)
		tx_byte = {7'h00, resp_trig} << `FBSS_TRIG_BIT;
	else
		// object then head temperature, high byte first
		tx_byte = snap[{bsel, 3'b000} +: 8];
end

// answer buffer toward the outer transmitter
fbss_buf2 #(
	.WIDTH(9)
) u_buf (
	.sys_clk_i(sys_clk_i),
	.srst_i(srst_i),
	.in_valid_i(resp_busy),
	.in_data_i({resp_idx == resp_len - 6'h01, tx_byte}),
	.in_ready_o(buf_ready),
	.out_valid_o(tx_valid_o),
	.out_data_o({tx_last_o, tx_data_o}),
	.out_ready_i(tx_ready_i)
);

// quiet watchdog and indicators
always @(posedge sys_clk_i) begin
	if (srst_i) begin
		quiet <= QUIET_CYC;
		blink <= 32'h0000_0000;
		led_red_o <= 1'b0;
		led_yellow_o <= 1'b0;
	end else begin
		if (frame_end && !fin_bad)
			quiet <= 32'h0000_0000;
		else if (!quiet_hit)
			quiet <= quiet + 32'h0000_0001;
		if (!quiet_hit) begin
			blink <= 32'h0000_0000;
			led_red_o <= 1'b0;
		end else if (blink >= BLINK_CYC - 1) begin
			blink <= 32'h0000_0000;
			led_red_o <= !led_red_o;
		end else begin
			blink <= blink + 32'h0000_0001;
		end
		led_yellow_o <= (state == `FBSS_ST_DX);
	end
end

// bit rate detection from shortest gap between line edges
always @(posedge sys_clk_i) begin
	if (srst_i) begin
		line_q <= 1'b1;
		gap <= 16'h0000;
		edges <= 4'h0;
		bit_period_o <= 16'hFFFF;
		rate_lock_o <= 1'b0;
	end else begin
		line_q <= line_rx_i;
		if (quiet_hit && !rate_lock_o) begin
			gap <= 16'h0000;
		end else if (line_q != line_rx_i) begin
			// keep the shortest bit time seen
			gap <= 16'h0001;
			if (gap != 16'h0000 && gap < bit_period_o)
				bit_period_o <= gap;
			if (edges != `FBSS_LOCK_EDGES)
				edges <= edges + 4'h1;
			else
				rate_lock_o <= (bit_period_o <= `FBSS_MAX_PER);
		end else if (gap != 16'hFFFF && gap != 16'h0000) begin
			gap <= gap + 16'h0001;
		end
		if (quiet_hit && rate_lock_o && line_q == line_rx_i && gap == 16'hFFFF) begin
			edges <= 4'h0;
			bit_period_o <= 16'hFFFF;
			rate_lock_o <= 1'b0;
		end
	end
end

endmodule // fbss_seq

// ---- bench/fbss_seq_sva.sv ----
// Purpose: port checks of the sequencer
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every sequencer
`timescale 1ns/1ps
module fbss_seq_sva (
	// clock and reset
	input wire sys_clk_i,
	input wire srst_i,
	// watched ports
	input wire rx_valid_i,
	input wire tx_valid_o,
	input wire [7:0] tx_data_o,
	input wire tx_last_o,
	input wire tx_ready_i,
	input wire app_we_o,
	input wire [15:0] bit_period_o,
	input wire rate_lock_o,
	input wire [3:0] heads_o,
	input wire led_red_o,
	input wire led_yellow_o
);
	reg at_first;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	// marks the first byte of each answer
	always @(posedge sys_clk_i) begin
		if (srst_i)
			at_first <= 1'b1;
		else if (tx_valid_o && tx_ready_i)
			at_first <= tx_last_o;
	end
	a_tx_byte_hold: assert property (
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
		else $error("answer byte changed before taken");
	a_first_type: assert property (
		tx_valid_o && at_first |-> tx_data_o inside {8'h10, 8'h11, 8'h12})
		else $error("answer starts with unknown type");
	a_ack_single: assert property (
		tx_valid_o && at_first && tx_data_o == 8'h10 |-> tx_last_o)
		else $error("ack longer than one byte");
	a_diag_two: assert property (
		tx_valid_o && at_first && tx_data_o == 8'h12 |-> !tx_last_o)
		else $error("diag without code byte");
	a_heads_max: assert property (
		heads_o <= 4'h8)
		else $error("more than eight heads");
	a_apply_exchange: assert property (
		app_we_o |-> led_yellow_o && $past(rx_valid_i))
		else $error("byte applied outside exchange");
	a_leds_apart: assert property (
		led_yellow_o |-> !led_red_o)
		else $error("red lit in exchange");
	a_rate_range: assert property (
		rate_lock_o |-> bit_period_o <= 16'h0A2C)
		else $error("locked period out of range");
endmodule // fbss_seq_sva
bind fbss_seq fbss_seq_sva u_fbss_seq_sva (.sys_clk_i, .srst_i, .rx_valid_i, .tx_valid_o,
	.tx_data_o, .tx_last_o, .tx_ready_i, .app_we_o, .bit_period_o, .rate_lock_o, .heads_o,
	.led_red_o, .led_yellow_o);

// ---- bench/fbss_master_model.sv ----
// Purpose: bus master that sends frames and takes answers
// Assumes: one byte per cycle toward the slave
// Notes: stall_i toggles the ready each cycle
`timescale 1ns/1ps
module fbss_master_model (
	// clock and control
	input wire sys_clk_i,
	input wire stall_i,
	// answer side
	input wire tx_valid_i,
	input wire [7:0] tx_data_i,
	input wire tx_last_i,
	output reg tx_ready_o,
	// request side
	output reg rx_valid_o,
	output reg [7:0] rx_data_o,
	output reg rx_last_o,
	output reg rx_err_o
);
	logic [7:0] ans[$];
	logic done;
	initial begin
		{rx_valid_o, rx_last_o, rx_err_o, done} = 4'h0;
		rx_data_o = 8'h00;
		tx_ready_o = 1'b1;
	end
	// collect answer bytes
	always @(posedge sys_clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			ans.push_back(tx_data_i);
			if (tx_last_i)
				done <= 1'b1;
		end
		tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;
	end
	task send(input logic [95:0] f, input int n, input logic err);
		int k;
		ans.delete();
		done = 1'b0;
		for (k = 0; k < n; k++) begin
			@(posedge sys_clk_i);
			rx_valid_o <= 1'b1;
			rx_data_o <= f[95-8*k -: 8];
			rx_last_o <= (k == n - 1);
			rx_err_o <= err;
		end
		@(posedge sys_clk_i);
		{rx_valid_o, rx_last_o, rx_err_o} <= 3'h0;
		rx_data_o <= ~rx_data_o; // released line
	endtask
endmodule // fbss_master_model

// ---- bench/tb_fbss_seq.sv ----
// Purpose: self-checking bench of the sequencer
// Assumes: master model drives frames
// Notes: short blink and quiet counts
`timescale 1ns/1ps
module tb_fbss_seq;
	typedef struct {logic [95:0] frm; int n; logic err; logic [47:0] ans; int alen;
		logic yel;} fbss_row_t;
	reg sys_clk_i, srst_i, line_rx_i, trigger_i, head_fault_i, stall, red_q;
	reg [6:0] station_addr;
	reg [127:0] obj_temp_i, head_temp_i;
	reg [15:0] app_last;
	wire rx_valid_i, rx_last_i, rx_err_i, tx_valid_o, tx_last_o, tx_ready_i;
	wire app_we_o, rate_lock_o, led_red_o, led_yellow_o;
	wire [7:0] rx_data_i, tx_data_o, app_idx_o, app_data_o;
	wire [15:0] bit_period_o;
	wire [3:0] heads_o;
	int err_total, check_count, k, n, app_cnt, red_tgl, lcnt;
	fbss_row_t rows[11];
	fbss_row_t r;
	fbss_seq #(.BLINK_CYC(20), .QUIET_CYC(400)) u_fbss_seq (.sys_clk_i, .srst_i,
		.station_addr_i(station_addr), .line_rx_i, .rx_valid_i, .rx_data_i, .rx_last_i, .rx_err_i,
		.trigger_i, .obj_temp_i, .head_temp_i, .head_fault_i, .tx_valid_o, .tx_data_o,
		.tx_last_o, .tx_ready_i, .app_we_o, .app_idx_o, .app_data_o, .bit_period_o,
		.rate_lock_o, .heads_o, .led_red_o, .led_yellow_o);
	fbss_master_model u_fbss_master_model (.sys_clk_i, .stall_i(stall),
		.tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_last_i(tx_last_o),
		.tx_ready_o(tx_ready_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
		.rx_last_o(rx_last_i), .rx_err_o(rx_err_i));
	// clock
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	// line edges every 5 cycles, applied bytes, red toggles
	always @(posedge sys_clk_i) begin
		lcnt <= (lcnt == 4) ? 0 : lcnt + 1;
		if (lcnt == 4)
			line_rx_i <= ~line_rx_i;
		if (app_we_o === 1'b1) begin
			app_cnt <= app_cnt + 1;
			app_last <= {app_idx_o, app_data_o};
		end
		red_q <= led_red_o;
		if (led_red_o !== red_q)
			red_tgl <= red_tgl + 1;
	end
	task chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task run(input fbss_row_t x);
		int i;
		u_fbss_master_model.send(x.frm, x.n, x.err);
		for (i = 0; i < 200 && u_fbss_master_model.done !== 1'b1; i++)
			@(posedge sys_clk_i);
		// an expected answer that never finishes ends the run
		if (x.alen != 0 && u_fbss_master_model.done !== 1'b1) begin
			chk(1'b0, "answer timeout");
			give_verdict;
		end
		chk(u_fbss_master_model.ans.size() == x.alen, "answer length");
		for (i = 0; i < x.alen && i < 6; i++)
			chk(u_fbss_master_model.ans[i] === x.ans[47-8*i -: 8], "answer byte");
		chk(led_yellow_o === x.yel, "yellow led");
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// main sequence
	initial begin
		{srst_i, trigger_i} = 2'h3;
		// line idles high, as the bus does
		{line_rx_i, head_fault_i, stall, red_q} = 4'h8;
		{err_total, check_count, app_cnt, red_tgl, lcnt} = 0;
		station_addr = 7'h05;
		app_last = 16'h0000;
		for (n = 0; n < 8; n++) begin
			obj_temp_i[16*n +: 16] = 16'h0100 * n + 16'h0023;
			head_temp_i[16*n +: 16] = 16'h0100 * n + 16'h0045;
		end
		rows[0] = '{96'h0503_AA00_0000_0000_0000_0000, 3, 0, 48'h1201_0000_0000, 2, 0};
		rows[1] = '{96'h0502_1251_0000_0000_0000_0000, 4, 0, 48'h1201_0000_0000, 2, 0};
		rows[2] = '{96'h0501_0000_0000_0000_0000_0000, 8, 0, 48'h1202_0000_0000, 2, 0};
		rows[3] = '{96'h0501_0000_0000_0000_0000_0000, 9, 1, 48'h1202_0000_0000, 2, 0};
		rows[4] = '{96'h0501_0000_0000_0000_0000_0000, 9, 0, 48'h1000_0000_0000, 1, 0};
		rows[5] = '{96'h0502_5100_0000_0000_0000_0000, 3, 0, 48'h1204_0000_0000, 2, 0};
		rows[6] = rows[4];
		rows[7] = '{96'h0502_1251_0000_0000_0000_0000, 4, 0, 48'h1000_0000_0000, 1, 1};
		rows[8] = '{96'h0503_0000_0000_0000_0000_0000, 3, 0, 48'h1101_0023_0045, 6, 1};
		rows[9] = '{96'h0503_0000_0000_0000_0000_0000, 3, 1, 48'h1208_0000_0000, 2, 1};
		rows[10] = '{96'h0601_0000_0000_0000_0000_0000, 9, 0, 48'h0, 0, 1};
		repeat (2) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		@(posedge sys_clk_i);
		#1;
		chk({tx_valid_o, heads_o, bit_period_o} === 21'h0_FFFF, "reset");
		for (k = 0; k < 11; k++)
			run(rows[k]);
		@(posedge sys_clk_i);
		head_fault_i <= 1'b1;
		@(posedge sys_clk_i);
		head_fault_i <= 1'b0;
		r = rows[9];
		r.ans = 48'h1210_0000_0000;
		r.err = 1'b0;
		run(r);
		// trigger low must clear the box bit
		trigger_i <= 1'b0;
		r = rows[8];
		r.ans = 48'h1100_0023_0045;
		run(r);
		trigger_i <= 1'b1;
		// nine heads refused, then a fresh start-up with eight
		run(rows[4]);
		r = rows[5];
		r.frm = 96'h0502_1251_5151_5151_5151_5151;
		r.n = 12;
		run(r);
		run(rows[4]);
		r = rows[7];
		r.frm = 96'h0502_1251_5151_5151_5151_5100;
		r.n = 11;
		run(r);
		app_cnt = 0;
		stall <= 1'b1;
		r = rows[8];
		r.frm = 96'h0503_A500_0000_0000_0000_0000;
		r.alen = 34;
		run(r);
		stall <= 1'b0;
		chk(heads_o === 4'h8 && app_cnt == 1 && app_last === 16'h00A5, "heads or apply");
		for (n = 0; n < 8; n++) begin
			chk({u_fbss_master_model.ans[2+4*n], u_fbss_master_model.ans[3+4*n]}
				=== obj_temp_i[16*n +: 16], "object temp");
			chk({u_fbss_master_model.ans[4+4*n], u_fbss_master_model.ans[5+4*n]}
				=== head_temp_i[16*n +: 16], "head temp");
		end
		red_tgl = 0;
		repeat (500) @(posedge sys_clk_i);
		chk(led_yellow_o === 1'b0 && red_tgl >= 4, "silent leds");
		run(rows[0]);
		chk(rate_lock_o === 1'b1 && bit_period_o === 16'h0005, "bit rate");
		// mid-run reset, then an address above the range
		srst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		station_addr <= 7'h7E;
		@(posedge sys_clk_i);
		#1;
		chk({heads_o, rate_lock_o, bit_period_o} === 21'h0_FFFF, "mid reset");
		r = rows[10];
		r.frm = 96'h7E01_0000_0000_0000_0000_0000;
		r.yel = 1'b0;
		run(r);
		give_verdict;
	end
endmodule // tb_fbss_seq
